/* File: hw/scs_pkg.sv */
package scs_pkg;
	// command code byte fields
	localparam int CC_END_BIT   = 0;
	localparam int CC_START_BIT = 1;
	localparam int CC_FUNC_LSB  = 2;
	localparam int CC_FUNC_W    = 3;
	localparam int CC_SIZE_LSB  = 5;
	localparam int CC_SIZE_W    = 2;
	localparam int CC_PEC_BIT   = 7;
	localparam logic [2:0] FUNC_CSR = 3'h0;
	typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_BLOCK, SIZE_RSVD}
		scs_size_e;
	localparam logic [7:0] BYTE_LEN = 8'h01;
	localparam logic [7:0] WORD_LEN = 8'h02;
	// command/status byte fields
	localparam int LANE_EN_LSB = 0;
	localparam int LANES       = 4;
	localparam int RNW_BIT     = 4;
	localparam int READ_UNCLAIMED_FLAG_BIT    = 6;
	localparam int WRITE_UNCLAIMED_FLAG_BIT    = 7;
	// field sequence after the command code (and length)
	localparam logic [2:0] FLD_CMD     = 3'h0;
	localparam logic [2:0] FLD_ADDR_LO = 3'h1;
	localparam logic [2:0] FLD_ADDR_HI = 3'h2;
	localparam logic [2:0] FLD_DATA0   = 3'h3;
	localparam logic [2:0] FLD_DONE    = 3'h7;
	localparam int FLD_NUM   = 7;
	localparam int BYTE_W    = 8;
	localparam int ADDR_W    = 14;
	localparam int ADDR_HI_W = 6;
	localparam int DATA_W    = 32;
	typedef enum logic [1:0] {LS_IDLE, LS_WR, LS_RD} scs_lstate_e;
endpackage : scs_pkg

/* File: hw/scs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,   // destination clock
	input  wire logic         srst_i,  // destination reset
	input  wire logic [W-1:0] d_i,     // foreign level
	output logic      [W-1:0] q_o      // synchronised level
);
	logic [W-1:0] s1_reg;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s1_reg <= '0;
			q_o    <= '0;
		end else begin
			s1_reg <= d_i;
			q_o    <= s1_reg;
		end
	end
endmodule : scs_sync
`default_nettype wire

/* File: hw/scs_xing.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_xing (
	input  wire logic src_clk_i,   // source clock
	input  wire logic src_srst_i,  // source reset
	input  wire logic src_pulse_i, // event, one source cycle
	input  wire logic dst_clk_i,   // destination clock
	input  wire logic dst_srst_i,  // destination reset
	output logic      dst_pulse_o  // event, one destination cycle
);
	logic tgl_reg;
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge src_clk_i) begin
		if (src_srst_i)
			tgl_reg <= 1'b0;
		else if (src_pulse_i)
			tgl_reg <= ~tgl_reg;
	end

	always_ff @(posedge dst_clk_i) begin
		if (dst_srst_i) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= tgl_reg;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign dst_pulse_o = s2_reg ^ s3_reg;
endmodule : scs_xing
`default_nettype wire

/* File: hw/scs_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_slave (
	input  wire logic                       clk_i,       // device clock
	input  wire logic                       srst_i,      // sync reset
	input  wire logic                       lnk_clk_i,   // link clock
	input  wire logic                       lnk_start_i, // start, addressed
	input  wire logic                       lnk_rd_i,    // start is a read
	input  wire logic                       lnk_wvld_i,  // byte from master
	input  wire logic [scs_pkg::BYTE_W-1:0] lnk_wdata_i, // received byte
	input  wire logic                       lnk_rreq_i,  // master wants byte
	input  wire logic                       lnk_stop_i,  // stop condition
	output logic                            lnk_ack_o,   // accept this
	output logic      [scs_pkg::BYTE_W-1:0] lnk_rdata_o, // byte to master
	output logic                            csr_req_o,   // access pending
	output logic                            csr_we_o,    // write access
	output logic      [scs_pkg::ADDR_W-1:0] csr_addr_o,  // dword index
	output logic      [scs_pkg::LANES-1:0]  csr_be_o,    // lane enables
	output logic      [scs_pkg::DATA_W-1:0] csr_wdata_o, // write data
	input  wire logic                       csr_done_i,  // access ended
	input  wire logic                       csr_claimed_i, // target claimed
	input  wire logic [scs_pkg::DATA_W-1:0] csr_rdata_i, // read data
	output logic                            read_unclaimed_flag_o,  // sticky
	output logic                            write_unclaimed_flag_o  // sticky
);
	import scs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// link domain state
	logic              lnk_srst;
	scs_lstate_e       st_reg;
	logic [7:0]        command_code_byte_reg;
	logic              cc_ok_reg;
	logic [3:0]        idx_reg;
	logic [7:0]        bcnt_reg;
	logic [3:0]        nfld_reg;
	logic [2:0]        fptr_reg;
	logic              busy_reg;
	logic [BYTE_W-1:0] fld_reg [FLD_NUM];
	logic [1:0]        flags_l;
	logic              done_evt_l;
	logic              launch;
	logic              clr_pulse;
	logic              wr_byte;
	logic              is_cc;
	logic              is_cnt;
	logic              is_fld;
	logic              cc_legal;
	logic              is_blk;
	scs_size_e         cur_size;
	scs_size_e         new_size;
	logic [7:0]        len_v;
	logic              rd_byte;
	logic              need_ok;
	logic [BYTE_W-1:0] rd_sel;

	////////////////////////////////////////////////////////////////////////
	// core domain state
	logic              req_evt_c;
	logic              clr_evt_c;
	logic              done_pulse;
	logic [DATA_W-1:0] rdata_reg;

	scs_sync #(.W(1)) u_rst_sync (
		.clk_i  (lnk_clk_i),
		.srst_i (1'b0),
		.d_i    (srst_i),
		.q_o    (lnk_srst)
	);

	scs_sync #(.W(2)) u_flag_sync (
		.clk_i  (lnk_clk_i),
		.srst_i (lnk_srst),
		.d_i    ({write_unclaimed_flag_o, read_unclaimed_flag_o}),
		.q_o    (flags_l)
	);

	scs_xing u_req_x (
		.src_clk_i   (lnk_clk_i),
		.src_srst_i  (lnk_srst),
		.src_pulse_i (launch),
		.dst_clk_i   (clk_i),
		.dst_srst_i  (srst_i),
		.dst_pulse_o (req_evt_c)
	);

	scs_xing u_clr_x (
		.src_clk_i   (lnk_clk_i),
		.src_srst_i  (lnk_srst),
		.src_pulse_i (clr_pulse),
		.dst_clk_i   (clk_i),
		.dst_srst_i  (srst_i),
		.dst_pulse_o (clr_evt_c)
	);

	scs_xing u_done_x (
		.src_clk_i   (clk_i),
		.src_srst_i  (srst_i),
		.src_pulse_i (done_pulse),
		.dst_clk_i   (lnk_clk_i),
		.dst_srst_i  (lnk_srst),
		.dst_pulse_o (done_evt_l)
	);

	////////////////////////////////////////////////////////////////////////
	// byte classification
	assign new_size = scs_size_e'(lnk_wdata_i[CC_SIZE_LSB +: CC_SIZE_W]);
	assign cur_size = scs_size_e'(command_code_byte_reg[CC_SIZE_LSB +: CC_SIZE_W]);
	assign cc_legal = lnk_wdata_i[CC_FUNC_LSB +: CC_FUNC_W] == FUNC_CSR
		&& new_size != SIZE_RSVD;
	assign is_blk  = cur_size == SIZE_BLOCK;
	assign wr_byte = st_reg == LS_WR && lnk_wvld_i;
	assign rd_byte = st_reg == LS_RD && lnk_rreq_i;
	assign is_cc   = wr_byte && idx_reg == 4'h0;
	assign is_cnt  = wr_byte && cc_ok_reg && idx_reg == 4'h1 && is_blk;
	// bytes past the length are the error check byte and are dropped
	assign len_v = is_blk ? bcnt_reg
		: (cur_size == SIZE_WORD ? WORD_LEN : BYTE_LEN);
	assign is_fld = wr_byte && cc_ok_reg && idx_reg != 4'h0 && !is_cnt
		&& {4'h0, nfld_reg} < len_v && fptr_reg != FLD_DONE;

	always_comb begin
		if (lnk_start_i)
			lnk_ack_o = !(lnk_rd_i && busy_reg);
		else if (is_cc)
			lnk_ack_o = cc_legal && !busy_reg;
		else if (wr_byte)
			lnk_ack_o = cc_ok_reg;
		else
			lnk_ack_o = 1'b0;
	end

	// read op only needs command and address before it may run
	assign need_ok = fld_reg[FLD_CMD][RNW_BIT] ? fptr_reg >= FLD_DATA0
		: fptr_reg == FLD_DONE;
	assign launch = lnk_stop_i && st_reg == LS_WR && cc_ok_reg
		&& command_code_byte_reg[CC_END_BIT] && {4'h0, nfld_reg} == len_v
		&& need_ok && !busy_reg;

	////////////////////////////////////////////////////////////////////////
	// link sequencing
	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			st_reg <= LS_IDLE;
		else if (lnk_start_i) begin
			case (lnk_rd_i)
				1'b1: st_reg <= busy_reg ? LS_IDLE : LS_RD;
				default: st_reg <= LS_WR;
			endcase
		end else if (lnk_stop_i)
			st_reg <= LS_IDLE;
	end

	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			idx_reg <= 4'h0;
		else if (lnk_start_i)
			idx_reg <= 4'h0;
		else if ((wr_byte || rd_byte) && idx_reg != 4'hF)
			idx_reg <= idx_reg + 4'h1;
	end

	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst) begin
			command_code_byte_reg <= 8'h00;
			cc_ok_reg <= 1'b0;
		end else if (is_cc) begin
			command_code_byte_reg <= lnk_wdata_i;
			cc_ok_reg <= cc_legal && !busy_reg;
		end
	end

	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			bcnt_reg <= 8'h00;
		else if (is_cnt)
			bcnt_reg <= lnk_wdata_i;
	end

	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			nfld_reg <= 4'h0;
		else if (lnk_start_i && !lnk_rd_i)
			nfld_reg <= 4'h0;
		else if (is_fld)
			nfld_reg <= nfld_reg + 4'h1;
	end

	// field pointer runs across transactions until a start code resets it
	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			fptr_reg <= FLD_CMD;
		else if (is_cc && cc_legal && !busy_reg
			&& lnk_wdata_i[CC_START_BIT])
			fptr_reg <= FLD_CMD;
		else if ((is_fld || (rd_byte && !(is_blk && idx_reg == 4'h0)))
			&& fptr_reg != FLD_DONE)
			fptr_reg <= fptr_reg + 3'h1;
	end

	genvar g;
	generate
		for (g = 0; g < FLD_NUM; g++) begin : g_fld
			always_ff @(posedge lnk_clk_i) begin
				if (lnk_srst)
					fld_reg[g] <= 8'h00;
				else if (is_fld && fptr_reg == 3'(g))
					fld_reg[g] <= lnk_wdata_i;
			end
		end
	endgenerate

	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			busy_reg <= 1'b0;
		else if (launch)
			busy_reg <= 1'b1;
		else if (done_evt_l)
			busy_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// read back: status, address, data in write order
	always_comb begin
		case (fptr_reg)
			FLD_CMD: rd_sel = {flags_l[1], flags_l[0], 1'b0,
				fld_reg[FLD_CMD][RNW_BIT:0]};
			FLD_ADDR_LO, FLD_ADDR_HI: rd_sel = fld_reg[fptr_reg];
			FLD_DONE: rd_sel = 8'h00;
			default: begin
				// rdata_reg is stable: only read after the done event
				if (fld_reg[FLD_CMD][RNW_BIT])
					rd_sel = rdata_reg[(fptr_reg - FLD_DATA0) * BYTE_W
						+: BYTE_W];
				else
					rd_sel = fld_reg[fptr_reg];
			end
		endcase
	end

	assign clr_pulse = rd_byte && !(is_blk && idx_reg == 4'h0)
		&& fptr_reg == FLD_CMD;

	always_ff @(posedge lnk_clk_i) begin
		if (lnk_srst)
			lnk_rdata_o <= 8'h00;
		else if (rd_byte) begin
			if (is_blk && idx_reg == 4'h0)
				lnk_rdata_o <= {5'h00, FLD_DONE - fptr_reg};
			else
				lnk_rdata_o <= rd_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// core access; link fields are frozen while busy
	always_ff @(posedge clk_i) begin
		if (srst_i)
			csr_req_o <= 1'b0;
		else if (req_evt_c)
			csr_req_o <= 1'b1;
		else if (csr_done_i)
			csr_req_o <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			csr_we_o    <= 1'b0;
			csr_addr_o  <= '0;
			csr_be_o    <= '0;
			csr_wdata_o <= '0;
		end else if (req_evt_c) begin
			csr_we_o    <= !fld_reg[FLD_CMD][RNW_BIT];
			csr_addr_o  <= {fld_reg[FLD_ADDR_HI][ADDR_HI_W-1:0],
				fld_reg[FLD_ADDR_LO]};
			csr_be_o    <= fld_reg[FLD_CMD][LANE_EN_LSB +: LANES];
			csr_wdata_o <= {fld_reg[FLD_DATA0 + 3'h3],
				fld_reg[FLD_DATA0 + 3'h2], fld_reg[FLD_DATA0 + 3'h1],
				fld_reg[FLD_DATA0]};
		end
	end

	assign done_pulse = csr_req_o && csr_done_i;

	always_ff @(posedge clk_i) begin
		if (srst_i)
			rdata_reg <= '0;
		else if (done_pulse && !csr_we_o)
			rdata_reg <= csr_rdata_i;
	end

	// set wins over the read-clear; claimed leaves the flag alone
	always_ff @(posedge clk_i) begin
		if (srst_i)
			read_unclaimed_flag_o <= 1'b0;
		else if (done_pulse && !csr_we_o && !csr_claimed_i)
			read_unclaimed_flag_o <= 1'b1;
		else if (clr_evt_c)
			read_unclaimed_flag_o <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (srst_i)
			write_unclaimed_flag_o <= 1'b0;
		else if (done_pulse && csr_we_o && !csr_claimed_i)
			write_unclaimed_flag_o <= 1'b1;
		else if (clr_evt_c)
			write_unclaimed_flag_o <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_req_start;
		req_evt_c;
	endsequence
	sequence s_req_fields;
		csr_addr_o == {fld_reg[FLD_ADDR_HI][ADDR_HI_W-1:0],
			fld_reg[FLD_ADDR_LO]}
		&& csr_be_o == fld_reg[FLD_CMD][LANE_EN_LSB +: LANES]
		&& csr_we_o == !fld_reg[FLD_CMD][RNW_BIT];
	endsequence

	property p_nack_busy;
		@(posedge lnk_clk_i) disable iff (lnk_srst)
		lnk_start_i && lnk_rd_i && busy_reg |-> !lnk_ack_o;
	endproperty
	a_nack_busy: assert property (p_nack_busy)
		else $error("read start taken while busy");

	property p_bad_func;
		@(posedge lnk_clk_i) disable iff (lnk_srst)
		is_cc && lnk_wdata_i[CC_FUNC_LSB +: CC_FUNC_W] != FUNC_CSR
		|-> !lnk_ack_o ##1 !cc_ok_reg;
	endproperty
	a_bad_func: assert property (p_bad_func)
		else $error("non-register function accepted");

	property p_bad_size;
		@(posedge lnk_clk_i) disable iff (lnk_srst)
		is_cc && new_size == SIZE_RSVD |-> !lnk_ack_o;
	endproperty
	a_bad_size: assert property (p_bad_size)
		else $error("reserved size accepted");

	property p_launch_busy;
		@(posedge lnk_clk_i) disable iff (lnk_srst)
		launch |=> busy_reg [*2];
	endproperty
	a_launch_busy: assert property (p_launch_busy)
		else $error("busy not held after launch");

	property p_req_fields;
		@(posedge clk_i) disable iff (srst_i)
		s_req_start |=> csr_req_o ##0 s_req_fields;
	endproperty
	a_req_fields: assert property (p_req_fields)
		else $error("access fields differ from command");

	property p_wdata_order;
		@(posedge clk_i) disable iff (srst_i)
		s_req_start |=> csr_wdata_o[BYTE_W-1:0] == fld_reg[FLD_DATA0];
	endproperty
	a_wdata_order: assert property (p_wdata_order)
		else $error("lowest data lane not first byte");

	property p_read_unclaimed_flag_set;
		@(posedge clk_i) disable iff (srst_i)
		done_pulse && !csr_we_o && !csr_claimed_i
		|=> read_unclaimed_flag_o;
	endproperty
	a_read_unclaimed_flag_set: assert property (p_read_unclaimed_flag_set)
		else $error("unclaimed read not flagged");

	property p_write_unclaimed_flag_set;
		@(posedge clk_i) disable iff (srst_i)
		done_pulse && csr_we_o && !csr_claimed_i
		|=> write_unclaimed_flag_o;
	endproperty
	a_write_unclaimed_flag_set: assert property (p_write_unclaimed_flag_set)
		else $error("unclaimed write not flagged");

	property p_claimed_keeps;
		@(posedge clk_i) disable iff (srst_i)
		done_pulse && csr_claimed_i && !clr_evt_c
		|=> $stable(read_unclaimed_flag_o)
			&& $stable(write_unclaimed_flag_o);
	endproperty
	a_claimed_keeps: assert property (p_claimed_keeps)
		else $error("claimed access changed a flag");

	property p_req_hold;
		@(posedge clk_i) disable iff (srst_i)
		csr_req_o && !csr_done_i |=> csr_req_o && $stable(csr_addr_o);
	endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("access dropped before done");
endmodule : scs_slave
`default_nettype wire

/* File: dv/scs_link_master.sv */
`timescale 1ns/1ps
`default_nettype none
module scs_link_master (
	output logic            lnk_clk_o, // link clock
	output logic            start_o,   // start condition
	output logic            rd_o,      // start is a read
	output logic            wvld_o,    // byte to slave
	output logic      [7:0] wdata_o,   // byte value
	output logic            rreq_o,    // byte wanted
	output logic            stop_o,    // stop condition
	input  wire logic       ack_i,     // slave accepts
	input  wire logic [7:0] rdata_i    // byte from slave
);
	logic       run = 1'b0;
	logic [7:0] rbuf [0:7];
	////////////////////////////////////////////////////////////
	// clock stands still low outside frames and idle stretches
	initial begin
		{lnk_clk_o, start_o, rd_o, wvld_o, rreq_o, stop_o} = '0;
		wdata_o = 8'hA5;
		#7;
		forever #80 lnk_clk_o = run ? ~lnk_clk_o : 1'b0;
	end
	task automatic xfer(input logic [4:0] k, input logic [7:0] d,
		output logic a);
		@(negedge lnk_clk_o);
		{start_o, rd_o, wvld_o, rreq_o, stop_o} = k;
		wdata_o = k[2] ? d : ~wdata_o; // released line toggles
		#70 a = ack_i;
		@(posedge lnk_clk_o);
		#1;
	endtask : xfer
	task automatic idle(input int n);
		logic a;
		run = 1'b1;
		repeat (n) xfer(5'h00, 8'h00, a);
		run = 1'b0;
	endtask : idle
	task automatic frame(input logic [7:0] b [0:9], input int n, m,
		output logic ok);
		logic a;
		ok = 1'b1;
		run = 1'b1;
		xfer(5'h10, 8'h00, a);
		for (int i = 0; i < n; i++) begin
			xfer(5'h04, b[i], a);
			ok &= a;
		end
		if (m > 0) begin
			xfer(5'h18, 8'h00, a);
			ok &= a;
			for (int i = 0; i < m && ok; i++) begin
				xfer(5'h02, 8'h00, a);
				rbuf[i] = rdata_i;
			end
		end
		xfer(5'h01, 8'h00, a);
		idle(3);
	endtask : frame
	// refused commands are retried, boundedly
	task automatic tx(input logic [7:0] b [0:9], input int n, m, t,
		output logic ok);
		for (int i = 0; i < t; i++) begin
			frame(b, n, m, ok);
			if (ok)
				break;
			idle(4);
		end
	endtask : tx
endmodule : scs_link_master
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import scs_pkg::*;
	logic              clk_i, srst_i, lnk_clk, st, rd, wv, rr, sp, ack, ok;
	logic              req, we, done, clm, rflag, wflag;
	logic [7:0]        wd, rdat;
	logic [ADDR_W-1:0] addr;
	logic [LANES-1:0]  be;
	logic [DATA_W-1:0] wdat, crd;
	logic [31:0]       mem [0:3];
	logic [50:0]       last;
	logic [63:0]       rb;
	int                err_count, num_checks, nacc, lat, hold;
	scs_link_master scs_link_master_i (.lnk_clk_o(lnk_clk), .start_o(st),
		.rd_o(rd), .wvld_o(wv), .wdata_o(wd), .rreq_o(rr), .stop_o(sp),
		.ack_i(ack), .rdata_i(rdat));
	scs_slave scs_slave_i (.clk_i(clk_i), .srst_i(srst_i),
		.lnk_clk_i(lnk_clk), .lnk_start_i(st), .lnk_rd_i(rd),
		.lnk_wvld_i(wv), .lnk_wdata_i(wd), .lnk_rreq_i(rr), .lnk_stop_i(sp),
		.lnk_ack_o(ack), .lnk_rdata_o(rdat), .csr_req_o(req), .csr_we_o(we),
		.csr_addr_o(addr), .csr_be_o(be), .csr_wdata_o(wdat),
		.csr_done_i(done), .csr_claimed_i(clm), .csr_rdata_i(crd),
		.read_unclaimed_flag_o(rflag), .write_unclaimed_flag_o(wflag));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////
	// target: answers 3 + hold cycles into a request, claims index 0..3
	initial begin
		{done, clm} = 2'b00;
		crd = '0;
		foreach (mem[i]) mem[i] = '0;
	end
	always @(negedge clk_i) begin
		lat = (req === 1'b1) ? lat + 1 : 0;
		done = (lat == 3 + hold);
		clm = done && addr < 4;
		crd = done ? mem[addr[1:0]] : ~crd;
		if (done) begin
			nacc++;
			last = {we, addr, be, wdat};
			for (int i = 0; i < 4; i++)
				if (we && clm && be[i])
					mem[addr[1:0]][8*i +: 8] = wdat[8*i +: 8];
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk
	task automatic send(input logic [7:0] b [0:9], input int n, m, t);
		scs_link_master_i.tx(b, n, m, t, ok);
	endtask : send
	task automatic wait_acc(input int n);
		for (int i = 0; i < 400 && nacc != n; i++)
			@(negedge clk_i);
		repeat (4) @(negedge clk_i);
		chk(nacc, n);
	endtask : wait_acc
	task automatic rdback(input logic [63:0] exp);
		send('{0:8'h42, default:8'h00}, 1, 8, 40);
		chk(ok, 1'b1);
		for (int i = 0; i < 8; i++)
			rb = {rb[55:0], scs_link_master_i.rbuf[i]};
		chk(rb, exp);
	endtask : rdback
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : print_verdict
	// watchdog: a hang counts as a mismatch
	initial begin
		repeat (90000) @(negedge clk_i);
		err_count++;
		$display("ERROR %0t: run did not finish", $time);
		print_verdict;
	end
	////////////////////////////////////////////////////////////
	initial begin
		srst_i = 1'b1;
		scs_link_master_i.idle(4);
		repeat (12) @(negedge clk_i);
		srst_i = 1'b0;
		scs_link_master_i.idle(4);
		// checksum byte past the length, top index bits set
		send('{8'hC3, 8'h07, 8'h0F, 8'h01, 8'hC0, 8'h11, 8'h22, 8'h33,
			8'h44, 8'h5A}, 10, 0, 40);
		chk(ok, 1'b1);
		wait_acc(1);
		chk(last, {1'b1, 14'h0001, 4'hF, 32'h44332211});
		send('{8'h43, 8'h07, 8'h05, 8'h01, 8'h00, 8'hAA, 8'hBB, 8'hCC,
			8'hDD, 8'h00}, 9, 0, 40);
		wait_acc(2);
		chk(last, {1'b1, 14'h0001, 4'h5, 32'hDDCCBBAA});
		send('{0:8'h43, 1:8'h03, 2:8'h1F, 3:8'h01, default:8'h00}, 5, 0, 40);
		wait_acc(3);
		chk(last[50:32], {1'b0, 14'h0001, 4'hF});
		rdback(64'h071F0100AA22CC44);
		// unclaimed write, then unclaimed read
		send('{0:8'h43, 1:8'h07, 2:8'h0F, 3:8'h10, 4:8'h2A,
			default:8'h00}, 9, 0, 40);
		wait_acc(4);
		chk(last[49:36], 14'h2A10);
		chk({rflag, wflag}, 2'b01);
		send('{0:8'h43, 1:8'h03, 2:8'h1F, 3:8'h10, 4:8'h2A,
			default:8'h00}, 5, 0, 40);
		wait_acc(5);
		chk({rflag, wflag}, 2'b11);
		rdback(64'h07DF102A00000000);
		repeat (20) @(negedge clk_i);
		chk({rflag, wflag}, 2'b00);
		rdback(64'h071F102A00000000);
		// reserved function and size codes
		for (int f = 1; f <= 8; f++) begin
			send('{0:(f == 8) ? 8'h63 : {3'b010, f[2:0], 2'b11},
				1:8'h07, 2:8'h0F, default:8'h00}, 9, 0, 1);
			chk(ok, 1'b0);
		end
		repeat (40) @(negedge clk_i);
		chk(nacc, 5);
		// word and byte transfers build one access
		send('{0:8'h22, 1:8'h0F, 2:8'h02, default:8'h00}, 3, 0, 40);
		send('{0:8'h20, 1:8'h00, 2:8'h01, default:8'h00}, 3, 0, 40);
		send('{0:8'h20, 1:8'h02, 2:8'h03, default:8'h00}, 3, 0, 40);
		send('{0:8'h01, 1:8'h04, default:8'h00}, 2, 0, 40);
		wait_acc(6);
		chk(last, {1'b1, 14'h0002, 4'hF, 32'h04030201});
		chk({rflag, wflag}, 2'b00);
		// slow target: a second command meets a busy slave
		hold = 200;
		send('{0:8'h43, 1:8'h07, 3:8'h03, default:8'h00}, 9, 0, 40);
		send('{0:8'h43, 1:8'h07, 3:8'h03, default:8'h00}, 3, 1, 1);
		chk(ok, 1'b0);
		wait_acc(7);
		chk(last[50:36], {1'b1, 14'h0003});
		print_verdict;
	end
endmodule : tb
`default_nettype wire
